// >>> design/gtec_top.sv
// Purpose: Echo, terminator and automatic END settings with their datapath.
// Assumes: Commands arrive already parsed through the command register.
// Notes: Serial and bus byte inputs are synchronous to clock_in.
`timescale 1ns/1ps
module gtec_top
    import gtec_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [BUS_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [BUS_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    input wire logic ser_rx_valid_in,
    input wire logic [BYTE_W-1:0] ser_rx_data_in,
    output logic ser_echo_valid_out,
    output logic [BYTE_W-1:0] ser_echo_data_out,
    input wire logic gpib_rd_valid_in,
    input wire logic [BYTE_W-1:0] gpib_rd_data_in,
    output logic gpib_rd_stop_out,
    input wire logic wr_valid_in,
    input wire logic [BYTE_W-1:0] wr_data_in,
    input wire logic wr_last_in,
    output logic wr_ready_out,
    output logic gpib_wr_valid_out,
    output logic [BYTE_W-1:0] gpib_wr_data_out,
    output logic gpib_eoi_out,
    input wire logic gpib_wr_ready_in
);
    typedef struct packed {
        logic ack;
        logic [BUS_W-1:0] rdata;
        logic echo_live;
        logic echo_pend;
        logic msg_start;
        logic eot;
        logic rstop;
        logic wend;
        logic full;
        logic [BYTE_W-1:0] eos_char;
        logic [BUS_W-1:0] reply;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_en;
        logic echo_v;
        logic [BYTE_W-1:0] echo_d;
        logic rd_stop;
        logic wr_v;
        logic [BYTE_W-1:0] wr_d;
        logic wr_eoi;
    } gtec_state_s;

    function automatic gtec_state_s with_defaults(input gtec_state_s s);
        gtec_state_s r;
        r = s;
        r.echo_live = RST_ECHO;
        r.echo_pend = RST_ECHO;
        r.eot = RST_EOT;
        r.rstop = RST_MODE;
        r.wend = RST_MODE;
        r.full = RST_MODE;
        r.eos_char = RST_EOS_CHAR;
        return r;
    endfunction

    gtec_state_s st_ff;
    gtec_state_s nxt_st;
    gtec_state_s zero_st;
    logic req;
    logic req_done;
    logic cmd_fire;
    logic [BUS_W-1:0] cmd;
    logic [1:0] cmd_op;
    logic is_term;
    logic echo_now;
    logic rd_match;
    logic wr_match;
    logic wr_accept;
    logic [IRQ_W-1:0] events;

    assign zero_st = '0;
    assign req = avs_read_in | avs_write_in;
    assign req_done = req & st_ff.ack;
    assign cmd = avs_writedata_in;
    assign cmd_op = cmd[CMD_OP_LSB +: 2];
    assign cmd_fire = req_done & avs_write_in & (avs_address_in == OFS_CMD)
        & avs_byteenable_in[0];
    assign is_term = (ser_rx_data_in == CHAR_CR) | (ser_rx_data_in == CHAR_LF);
    assign echo_now = st_ff.echo_live
        | (st_ff.echo_pend & st_ff.msg_start & ~is_term);
    assign wr_accept = wr_valid_in & wr_ready_out;

    gtec_match u_rd_match (
        .data_in(gpib_rd_data_in),
        .eos_char_in(st_ff.eos_char),
        .full_byte_compare_in(st_ff.full),
        .match_out(rd_match)
    );

    gtec_match u_wr_match (
        .data_in(wr_data_in),
        .eos_char_in(st_ff.eos_char),
        .full_byte_compare_in(st_ff.full),
        .match_out(wr_match)
    );

    always_comb begin
        nxt_st = st_ff;
        events = '0;

        // Bus slave: one wait cycle, then data and write effect.
        nxt_st.ack = req & ~st_ff.ack;
        if (req & ~st_ff.ack & avs_read_in) begin
            nxt_st.rdata = '0;
            case (avs_address_in)
                OFS_REPLY: begin
                    nxt_st.rdata = st_ff.reply;
                end
                OFS_SETTINGS: begin
                    nxt_st.rdata[SET_ECHO] = st_ff.echo_live;
                    nxt_st.rdata[SET_ECHO_PEND] = st_ff.echo_pend;
                    nxt_st.rdata[SET_EOT] = st_ff.eot;
                    nxt_st.rdata[SET_RSTOP] = st_ff.rstop;
                    nxt_st.rdata[SET_WEND] = st_ff.wend;
                    nxt_st.rdata[SET_FULL] = st_ff.full;
                    nxt_st.rdata[SET_CHAR_LSB +: BYTE_W] = st_ff.eos_char;
                end
                OFS_IRQ_STATUS: begin
                    nxt_st.rdata[IRQ_W-1:0] = st_ff.irq_st;
                end
                OFS_IRQ_ENABLE: begin
                    nxt_st.rdata[IRQ_W-1:0] = st_ff.irq_en;
                end
                default: begin
                    nxt_st.rdata = '0;
                end
            endcase
        end

        // Serial echo and message boundary tracking.
        nxt_st.echo_v = 1'b0;
        if (ser_rx_valid_in) begin
            if (echo_now) begin
                nxt_st.echo_v = 1'b1;
                nxt_st.echo_d = ser_rx_data_in;
            end
            if (is_term) begin
                nxt_st.msg_start = 1'b1;
            end else begin
                nxt_st.msg_start = 1'b0;
                if (st_ff.echo_pend & st_ff.msg_start) begin
                    nxt_st.echo_live = 1'b1;
                    nxt_st.echo_pend = 1'b0;
                end
            end
        end

        // Read termination on a terminator match.
        nxt_st.rd_stop = gpib_rd_valid_in & st_ff.rstop & rd_match;
        events[IRQ_RDSTOP] = nxt_st.rd_stop;

        // Write output stage holds byte and EOI until the handshake ends.
        if (st_ff.wr_v & gpib_wr_ready_in) begin
            nxt_st.wr_v = 1'b0;
        end
        if (wr_accept) begin
            nxt_st.wr_v = 1'b1;
            nxt_st.wr_d = wr_data_in;
            nxt_st.wr_eoi = (st_ff.wend & wr_match)
                | (st_ff.eot & wr_last_in);
            events[IRQ_WREND] = nxt_st.wr_eoi;
        end

        // Command execution; settings otherwise hold their value.
        if (cmd_fire) begin
            case (cmd_op)
                GTEC_OP_ECHO: begin
                    if (!cmd[CMD_HAS_ARG]) begin
                        nxt_st.reply = '0;
                        nxt_st.reply[REPLY_BOOL] =
                            st_ff.echo_live | st_ff.echo_pend;
                        events[IRQ_REPLY] = 1'b1;
                    end else if (cmd[CMD_BOOL]) begin
                        if (!st_ff.echo_live) begin
                            nxt_st.echo_pend = 1'b1;
                        end
                    end else begin
                        nxt_st.echo_live = 1'b0;
                        nxt_st.echo_pend = 1'b0;
                    end
                end
                GTEC_OP_EOS: begin
                    if (!cmd[CMD_HAS_ARG]) begin
                        nxt_st.reply = '0;
                        nxt_st.reply[REPLY_CHAR_LSB +: BYTE_W] =
                            st_ff.eos_char;
                        nxt_st.reply[REPLY_LET_R] = st_ff.rstop;
                        nxt_st.reply[REPLY_LET_X] = st_ff.wend;
                        nxt_st.reply[REPLY_LET_B] = st_ff.full;
                        events[IRQ_REPLY] = 1'b1;
                    end else if (cmd[CMD_LET_D]) begin
                        nxt_st.rstop = 1'b0;
                        nxt_st.wend = 1'b0;
                        nxt_st.full = 1'b0;
                    end else if (cmd[CMD_LET_B] & ~cmd[CMD_LET_R]
                        & ~cmd[CMD_LET_X]) begin
                        events[IRQ_BADARG] = 1'b1;
                    end else begin
                        nxt_st.rstop = cmd[CMD_LET_R];
                        nxt_st.wend = cmd[CMD_LET_X];
                        nxt_st.full = cmd[CMD_LET_B];
                        nxt_st.eos_char = cmd[CMD_CHAR_LSB +: BYTE_W];
                    end
                end
                GTEC_OP_EOT: begin
                    if (!cmd[CMD_HAS_ARG]) begin
                        nxt_st.reply = '0;
                        nxt_st.reply[REPLY_BOOL] = st_ff.eot;
                        events[IRQ_REPLY] = 1'b1;
                    end else begin
                        nxt_st.eot = cmd[CMD_BOOL];
                    end
                end
                GTEC_OP_ONL: begin
                    nxt_st = with_defaults(nxt_st);
                end
                default: begin
                    nxt_st.reply = st_ff.reply;
                end
            endcase
            nxt_st.reply[REPLY_OP_LSB +: 2] = cmd_op;
        end

        // Interrupt registers; a new event wins over its clear.
        if (req_done & avs_write_in) begin
            if (avs_address_in == OFS_IRQ_ENABLE && avs_byteenable_in[0]) begin
                nxt_st.irq_en = avs_writedata_in[IRQ_W-1:0];
            end
            if (avs_address_in == OFS_IRQ_CLEAR && avs_byteenable_in[0]) begin
                nxt_st.irq_st = st_ff.irq_st & ~avs_writedata_in[IRQ_W-1:0];
            end
        end
        nxt_st.irq_st = nxt_st.irq_st | events;
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            st_ff <= with_defaults(zero_st);
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_waitrequest_out = req & ~st_ff.ack;
    assign avs_readdata_out = st_ff.rdata;
    assign irq_out = |(st_ff.irq_st & st_ff.irq_en);
    assign ser_echo_valid_out = st_ff.echo_v;
    assign ser_echo_data_out = st_ff.echo_d;
    assign gpib_rd_stop_out = st_ff.rd_stop;
    assign wr_ready_out = ~st_ff.wr_v | gpib_wr_ready_in;
    assign gpib_wr_valid_out = st_ff.wr_v;
    assign gpib_wr_data_out = st_ff.wr_d;
    assign gpib_eoi_out = st_ff.wr_v & st_ff.wr_eoi;

    a_echo_off_quiet: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        ser_rx_valid_in && !echo_now |=> !ser_echo_valid_out)
        else $error("Character echoed while echo is off.");

    a_echo_copies_byte: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        ser_rx_valid_in && st_ff.echo_live |=> ser_echo_valid_out
        && ser_echo_data_out == $past(ser_rx_data_in))
        else $error("Echoed byte differs from received byte.");

    a_echo_enable_defer: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        cmd_fire && cmd_op == GTEC_OP_ECHO && cmd[CMD_HAS_ARG]
        && cmd[CMD_BOOL] && !st_ff.echo_live && !ser_rx_valid_in
        |=> !st_ff.echo_live && st_ff.echo_pend)
        else $error("Echo went live inside the enabling message.");

    a_read_stop_match: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        gpib_rd_valid_in && st_ff.rstop && !st_ff.full
        && gpib_rd_data_in[6:0] == st_ff.eos_char[6:0]
        |=> gpib_rd_stop_out)
        else $error("Read did not stop on seven-bit match.");

    a_read_full_compare: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        gpib_rd_valid_in && st_ff.rstop && st_ff.full
        && gpib_rd_data_in != st_ff.eos_char |=> !gpib_rd_stop_out)
        else $error("Read stopped without full byte match.");

    a_eoi_last_byte: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        wr_accept && st_ff.eot && wr_last_in
        |=> gpib_wr_valid_out && gpib_eoi_out)
        else $error("Final write byte left without END.");

    a_eoi_held_handshake: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        gpib_wr_valid_out && !gpib_wr_ready_in |=> gpib_wr_valid_out
        && $stable(gpib_eoi_out) && $stable(gpib_wr_data_out))
        else $error("Write byte or EOI changed during handshake.");

    a_write_data_kept: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        wr_accept |=> gpib_wr_data_out == $past(wr_data_in))
        else $error("Write data altered on its way to the bus.");

    a_bad_argument_flag: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        cmd_fire && cmd_op == GTEC_OP_EOS && cmd[CMD_HAS_ARG]
        && cmd[CMD_LET_B] && !cmd[CMD_LET_R] && !cmd[CMD_LET_X]
        && !cmd[CMD_LET_D]
        |=> st_ff.irq_st[IRQ_BADARG] && $stable(st_ff.full))
        else $error("Lone full compare letter not rejected.");

    a_eot_query_reply: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        cmd_fire && cmd_op == GTEC_OP_EOT && !cmd[CMD_HAS_ARG]
        |=> st_ff.reply[REPLY_BOOL] == $past(st_ff.eot))
        else $error("END query reply does not match setting.");

    a_online_defaults: assert property (@(posedge clock_in)
        disable iff (!rst_b_in)
        cmd_fire && cmd_op == GTEC_OP_ONL |=> st_ff.eot && !st_ff.rstop
        && !st_ff.wend && !st_ff.echo_live && !st_ff.echo_pend)
        else $error("Go-online did not restore defaults.");
endmodule

// >>> design/gtec_pkg.sv
// Purpose: Shared constants for the termination and echo controller.
// Assumes: Avalon-MM slave with byte addresses and 32-bit data.
// Notes: All register offsets, field positions and reset values live here.
package gtec_pkg;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 5;
    localparam int BYTE_W = 8;
    localparam int IRQ_W = 4;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CMD = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_REPLY = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_SETTINGS = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 5'h14;

    // Command register fields.
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_HAS_ARG = 2;
    localparam int CMD_BOOL = 3;
    localparam int CMD_LET_R = 4;
    localparam int CMD_LET_X = 5;
    localparam int CMD_LET_B = 6;
    localparam int CMD_LET_D = 7;
    localparam int CMD_CHAR_LSB = 8;

    typedef enum logic [1:0] {
        GTEC_OP_ECHO = 2'h0,
        GTEC_OP_EOS = 2'h1,
        GTEC_OP_EOT = 2'h2,
        GTEC_OP_ONL = 2'h3
    } gtec_op_e;

    // Settings register fields.
    localparam int SET_ECHO = 0;
    localparam int SET_ECHO_PEND = 1;
    localparam int SET_EOT = 2;
    localparam int SET_RSTOP = 3;
    localparam int SET_WEND = 4;
    localparam int SET_FULL = 5;
    localparam int SET_CHAR_LSB = 8;

    // Reply register fields.
    localparam int REPLY_BOOL = 0;
    localparam int REPLY_CHAR_LSB = 0;
    localparam int REPLY_LET_R = 8;
    localparam int REPLY_LET_X = 9;
    localparam int REPLY_LET_B = 10;
    localparam int REPLY_OP_LSB = 16;

    // Interrupt status bits.
    localparam int IRQ_REPLY = 0;
    localparam int IRQ_BADARG = 1;
    localparam int IRQ_RDSTOP = 2;
    localparam int IRQ_WREND = 3;

    // Reset and go-online defaults.
    localparam logic RST_ECHO = 1'b0;
    localparam logic RST_EOT = 1'b1;
    localparam logic RST_MODE = 1'b0;
    localparam logic [BYTE_W-1:0] RST_EOS_CHAR = 8'h00;

    localparam logic [BYTE_W-1:0] CHAR_CR = 8'h0d;
    localparam logic [BYTE_W-1:0] CHAR_LF = 8'h0a;
    localparam logic [BYTE_W-1:0] LOW7_MASK = 8'h7f;
endpackage

// >>> design/gtec_match.sv
// Purpose: Compares one data byte against the terminator character.
// Assumes: Purely combinational; used for both read and write paths.
// Notes: Narrow compare looks only at the low seven bits.
`timescale 1ns/1ps
module gtec_match
    import gtec_pkg::*;
(
    input wire logic [BYTE_W-1:0] data_in,
    input wire logic [BYTE_W-1:0] eos_char_in,
    input wire logic full_byte_compare_in,
    output logic match_out
);
    always_comb begin
        if (full_byte_compare_in) begin
            match_out = (data_in == eos_char_in);
        end else begin
            match_out = ((data_in & LOW7_MASK) == (eos_char_in & LOW7_MASK));
        end
    end
endmodule

// >>> testbench/gtec_bus_listener.sv
// Purpose: Bus listener that accepts bytes written by the block.
// Assumes: A byte is taken at an edge where valid and ready are both high.
// Notes: Slow mode holds ready off so that byte and EOI must stand.
`timescale 1ns/1ps
module gtec_bus_listener
    import gtec_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic slow_in,
    input wire logic valid_in,
    input wire logic [BYTE_W-1:0] data_in,
    input wire logic eoi_in,
    output logic ready_out,
    output logic [BYTE_W-1:0] got_data_out,
    output logic got_eoi_out,
    output int got_count_out,
    output int hold_faults_out
);
    logic [1:0] wait_ff;
    logic [BYTE_W-1:0] last_data_ff;
    logic last_eoi_ff;

    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            ready_out <= 1'b0;
            wait_ff <= 2'h0;
            got_count_out <= 0;
            hold_faults_out <= 0;
        end else if (valid_in && ready_out) begin
            got_data_out <= data_in;
            got_eoi_out <= eoi_in;
            got_count_out <= got_count_out + 1;
            ready_out <= 1'b0;
            wait_ff <= 2'h0;
        end else if (valid_in) begin
            // A byte waiting on the bus must not change under the listener.
            if (wait_ff != 2'h0 && (data_in !== last_data_ff ||
                eoi_in !== last_eoi_ff)) begin
                hold_faults_out <= hold_faults_out + 1;
            end
            last_data_ff <= data_in;
            last_eoi_ff <= eoi_in;
            if (wait_ff != 2'h3) begin
                wait_ff <= wait_ff + 2'h1;
            end
            ready_out <= !slow_in || wait_ff == 2'h3;
        end else begin
            ready_out <= 1'b0;
        end
    end
endmodule

// >>> testbench/gtec_top_tb_top.sv
// Purpose: Self-checking bench for the echo and termination controller.
// Assumes: Commands are written already parsed into the command register.
// Notes: Every wait is bounded; a hang ends the run as a failure.
`timescale 1ns/1ps
module gtec_top_tb_top
    import gtec_pkg::*;
;
    localparam logic [5:0] F_ARG = 6'h01;
    localparam logic [5:0] F_ONE = 6'h02;
    localparam logic [5:0] F_R = 6'h04;
    localparam logic [5:0] F_X = 6'h08;
    localparam logic [5:0] F_B = 6'h10;
    localparam logic [5:0] F_D = 6'h20;
    logic clock_in, rst_b_in, avs_read_in, avs_write_in, irq_out;
    logic [ADDR_W-1:0] avs_address_in;
    logic [BUS_W-1:0] avs_writedata_in, avs_readdata_out;
    logic avs_waitrequest_out, ser_rx_valid_in, ser_echo_valid_out;
    logic [BYTE_W-1:0] ser_rx_data_in, ser_echo_data_out, gpib_rd_data_in;
    logic gpib_rd_valid_in, gpib_rd_stop_out, wr_valid_in, wr_last_in;
    logic [BYTE_W-1:0] wr_data_in, gpib_wr_data_out, got_data;
    logic wr_ready_out, gpib_wr_valid_out, gpib_eoi_out, gpib_wr_ready_in;
    logic got_eoi, slow;
    logic [3:0] be;
    int got_count, hold_faults, n_errors, checks;

    gtec_top uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(be), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
        .ser_rx_valid_in(ser_rx_valid_in), .ser_rx_data_in(ser_rx_data_in),
        .ser_echo_valid_out(ser_echo_valid_out),
        .ser_echo_data_out(ser_echo_data_out),
        .gpib_rd_valid_in(gpib_rd_valid_in),
        .gpib_rd_data_in(gpib_rd_data_in),
        .gpib_rd_stop_out(gpib_rd_stop_out), .wr_valid_in(wr_valid_in),
        .wr_data_in(wr_data_in), .wr_last_in(wr_last_in),
        .wr_ready_out(wr_ready_out), .gpib_wr_valid_out(gpib_wr_valid_out),
        .gpib_wr_data_out(gpib_wr_data_out), .gpib_eoi_out(gpib_eoi_out),
        .gpib_wr_ready_in(gpib_wr_ready_in));

    gtec_bus_listener partner (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .slow_in(slow), .valid_in(gpib_wr_valid_out),
        .data_in(gpib_wr_data_out), .eoi_in(gpib_eoi_out),
        .ready_out(gpib_wr_ready_in), .got_data_out(got_data),
        .got_eoi_out(got_eoi), .got_count_out(got_count),
        .hold_faults_out(hold_faults));

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = !clock_in;
    end

    task automatic end_sim;
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic hang;
        n_errors++;
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low at a falling edge.
    task automatic av(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d, output logic [31:0] q);
        logic w;
        int i;
        @(posedge clock_in);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        for (i = 0; i < 20; i++) begin
            @(negedge clock_in);
            w = avs_waitrequest_out;
            q = avs_readdata_out;
            @(posedge clock_in);
            if (!w) break;
        end
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (i == 20) hang();
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        av(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hffff_ffff);
        logic [31:0] q;
        av(1'b0, a, 32'h0000_0000, q);
        chk(q & m, e);
    endtask

    task automatic cmd(input logic [1:0] op, input logic [5:0] f,
        input logic [7:0] ch);
        wr(OFS_CMD, {16'h0000, ch, f, op});
    endtask

    task automatic ser(input logic [7:0] ch, input logic echoed);
        @(posedge clock_in);
        ser_rx_valid_in <= 1'b1;
        ser_rx_data_in <= ch;
        @(posedge clock_in);
        ser_rx_valid_in <= 1'b0;
        @(negedge clock_in);
        chk(ser_echo_valid_out, echoed);
        if (echoed) chk(ser_echo_data_out, ch);
    endtask

    task automatic gread(input logic [7:0] b, input logic stop);
        @(posedge clock_in);
        gpib_rd_valid_in <= 1'b1;
        gpib_rd_data_in <= b;
        @(posedge clock_in);
        gpib_rd_valid_in <= 1'b0;
        @(negedge clock_in);
        chk(gpib_rd_stop_out, stop);
    endtask

    task automatic wbyte(input logic [7:0] b, input logic last,
        input logic eoi);
        logic r;
        int i;
        int n0;
        n0 = got_count;
        @(posedge clock_in);
        wr_valid_in <= 1'b1;
        wr_data_in <= b;
        wr_last_in <= last;
        for (i = 0; i < 20; i++) begin
            @(negedge clock_in);
            r = wr_ready_out;
            @(posedge clock_in);
            if (r) break;
        end
        wr_valid_in <= 1'b0;
        for (i = 0; i < 20 && got_count == n0; i++) @(negedge clock_in);
        if (i == 20) hang();
        chk(got_data, b);
        chk(got_eoi, eoi);
    endtask

    task automatic echo_test;
        ser(8'h41, 1'b0);
        cmd(GTEC_OP_ECHO, F_ARG | F_ONE, 8'h00);
        rd_chk(OFS_SETTINGS, 32'h0000_0006);
        ser(8'h42, 1'b0);
        ser(CHAR_CR, 1'b0);
        ser(8'h43, 1'b1);
        ser(8'h44, 1'b1);
        cmd(GTEC_OP_ECHO, 6'h00, 8'h00);
        rd_chk(OFS_REPLY, 32'h0000_0001);
        rd_chk(OFS_SETTINGS, 32'h0000_0005);
        cmd(GTEC_OP_ECHO, F_ARG, 8'h00);
        ser(8'h45, 1'b0);
    endtask

    task automatic eos_test;
        cmd(GTEC_OP_EOS, F_ARG | F_R, 8'h0a);
        gread(8'h8a, 1'b1);
        gread(8'h0b, 1'b0);
        cmd(GTEC_OP_EOS, F_ARG | F_R | F_B, 8'h0a);
        gread(8'h8a, 1'b0);
        gread(8'h0a, 1'b1);
        cmd(GTEC_OP_EOS, 6'h00, 8'h00);
        rd_chk(OFS_REPLY, 32'h0001_050a);
        cmd(GTEC_OP_EOS, F_ARG | F_R | F_X, 8'h0d);
        rd_chk(OFS_SETTINGS, 32'h0000_0d1c);
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0005);
        wr(OFS_IRQ_CLEAR, 32'h0000_000f);
        cmd(GTEC_OP_EOS, F_ARG | F_B, 8'h55);
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
        rd_chk(OFS_SETTINGS, 32'h0000_0d1c);
        chk(irq_out, 1'b0);
        wr(OFS_IRQ_ENABLE, 32'h0000_0002);
        @(negedge clock_in);
        chk(irq_out, 1'b1);
        wr(OFS_IRQ_CLEAR, 32'h0000_0002);
        @(negedge clock_in);
        chk(irq_out, 1'b0);
        cmd(GTEC_OP_EOS, F_ARG | F_D, 8'h00);
        rd_chk(OFS_SETTINGS, 32'h0000_0d04);
    endtask

    task automatic write_test;
        cmd(GTEC_OP_EOT, F_ARG, 8'h00);
        cmd(GTEC_OP_EOT, 6'h00, 8'h00);
        rd_chk(OFS_REPLY, 32'h0002_0000);
        cmd(GTEC_OP_EOS, F_ARG | F_X, 8'h0d);
        wbyte(8'h41, 1'b0, 1'b0);
        wbyte(8'h8d, 1'b0, 1'b1);
        wbyte(8'h0e, 1'b1, 1'b0);
        slow <= 1'b1;
        cmd(GTEC_OP_EOS, F_ARG | F_X | F_B, 8'h0d);
        wbyte(8'h8d, 1'b0, 1'b0);
        wbyte(8'h0d, 1'b0, 1'b1);
        cmd(GTEC_OP_EOS, F_ARG | F_D, 8'h0d);
        cmd(GTEC_OP_EOT, F_ARG | F_ONE, 8'h00);
        wbyte(8'h0d, 1'b0, 1'b0);
        wbyte(8'h42, 1'b1, 1'b1);
        cmd(GTEC_OP_EOT, 6'h00, 8'h00);
        rd_chk(OFS_REPLY, 32'h0002_0001);
        repeat (8) @(negedge clock_in);
        chk(got_count, 7);
        chk(hold_faults, 0);
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0009);
    endtask

    task automatic online_test;
        cmd(GTEC_OP_ECHO, F_ARG | F_ONE, 8'h00);
        cmd(GTEC_OP_EOS, F_ARG | F_R, 8'h21);
        cmd(GTEC_OP_EOT, F_ARG, 8'h00);
        rd_chk(OFS_SETTINGS, 32'h0000_210a);
        // A command written with lane 0 disabled must be ignored.
        be <= 4'he;
        cmd(GTEC_OP_ONL, 6'h00, 8'h00);
        be <= 4'hf;
        rd_chk(OFS_SETTINGS, 32'h0000_210a);
        cmd(GTEC_OP_ONL, 6'h00, 8'h00);
        rd_chk(OFS_SETTINGS, 32'h0000_0004);
        // A second reset in mid-run restores the power-on settings.
        cmd(GTEC_OP_EOT, F_ARG, 8'h00);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rd_chk(OFS_SETTINGS, 32'h0000_0004);
    endtask

    initial begin
        n_errors = 0;
        checks = 0;
        rst_b_in = 1'b0;
        slow = 1'b0;
        be = 4'hf;
        {avs_read_in, avs_write_in, ser_rx_valid_in, gpib_rd_valid_in} = 4'h0;
        {wr_valid_in, wr_last_in} = 2'h0;
        avs_address_in = 5'h00;
        avs_writedata_in = 32'h0000_0000;
        {ser_rx_data_in, gpib_rd_data_in, wr_data_in} = 24'h00_0000;
        repeat (10) @(posedge clock_in);
        rst_b_in <= 1'b1;
        rd_chk(OFS_SETTINGS, 32'h0000_0004);
        rd_chk(5'h1c, 32'h0000_0000);
        echo_test();
        eos_test();
        write_test();
        online_test();
        end_sim();
    end
endmodule
